/* File: hdl/radio_regs_cfg.svh */
// register map, field positions, reset values and timing counts of the radio register bank
`ifndef RADIO_REGS_CFG_SVH
`define RADIO_REGS_CFG_SVH

// ************************************************
// register addresses (7-bit spi address space)
// ************************************************
`define ADDR_SYNTH_LOCK 7'h03
`define ADDR_SIGNAL 7'h06
`define ADDR_TXRX 7'h07
`define ADDR_AMP 7'h09
`define ADDR_OSC 7'h0a
`define ADDR_CARRIER 7'h0b
`define ADDR_CAL 7'h17
`define ADDR_SLEEP 7'h1b
`define ADDR_REVISION 7'h1d
`define ADDR_SIGNATURE 7'h1e
`define ADDR_SILICON 7'h1f

// ************************************************
// field positions
// ************************************************
`define LOCK_BIT 12
`define SIGNAL_LSB 10
`define TX_START_BIT 8
`define RX_START_BIT 7
`define CHANNEL_LSB 0
`define GAIN_LSB 7
`define OSC_BIT 0
`define CARRIER_BIT 15
`define METER_OFF_BIT 9
`define AUTO_CAL_BIT 2
`define SLEEP_LSB 11
`define RF_REV_LSB 4
`define DIG_REV_LSB 0
`define CMD_READ_BIT 6

// ************************************************
// reset and fixed values
// ************************************************
`define CHANNEL_RESET 7'h00
`define GAIN_RESET 4'h0
`define SLEEP_RESET 5'h00
`define RADIO_REVISION 4'h1
`define DIGITAL_REVISION 3'h1
// arbitrary signature and identity codes
`define SIGNATURE_VALUE 16'h5a5a
`define SILICON_ID_A 16'h0a01
`define SILICON_ID_B 16'h0b01

// ************************************************
// timing
// ************************************************
`define CLOCK_PERIOD_NS 40
`define CAL_TIME_NS 1000
`define CAL_CYCLES ((`CAL_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define FRAME_LAST_BIT 5'h17
`define CMD_LAST_BIT 5'h07

`endif

/* File: hdl/radio_regs_pkg.sv */
// types shared by the radio register bank and its spi frame engine
package radio_regs_pkg;

   // radio control states, one-hot
   typedef enum logic [3:0] {
      st_idle = 4'b0001,
      st_cal = 4'b0010,
      st_tx = 4'b0100,
      st_rx = 4'b1000
   } radio_state_e;

   // one register access decoded from a spi frame
   typedef struct packed {
      logic write;
      logic [6:0] addr;
      logic [15:0] wdata;
   } reg_access_s;

   // controls driven into the analog radio
   typedef struct packed {
      logic [6:0] channel_number;
      logic [3:0] amplifier_gain;
      logic osc_gain_enable;
      logic carrier_only;
      logic signal_meter_off;
      logic [4:0] regulator_sleep_current;
      logic cal_active;
      logic tx_active;
      logic rx_active;
   } radio_ctrl_s;

   // status coming back from the analog radio
   typedef struct packed {
      logic synth_locked;
      logic [5:0] raw_signal_level;
   } analog_status_s;

endpackage

/* File: hdl/spi_frame_engine.sv */
// spi slave that turns 24-bit frames into register reads and writes
`timescale 1ns/1ns
`include "radio_regs_cfg.svh"
module spi_frame_engine import radio_regs_pkg::*; (
   // system
   input wire logic clock,
   input wire logic reset,
   // spi pins
   input wire logic spi_ss_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // register side
   input wire logic [15:0] read_data,
   output reg_access_s access
);

   logic sclk_prev, next_sclk_prev;
   logic [4:0] bit_count, next_bit_count;
   logic [15:0] rx_shift, next_rx_shift;
   logic [15:0] tx_shift, next_tx_shift;
   logic is_read, next_is_read;
   logic load_pending, next_load_pending;
   reg_access_s next_access;
   logic rise, fall;

   assign rise = spi_sclk & ~sclk_prev;
   assign fall = ~spi_sclk & sclk_prev;
   // pins are synchronous to clock, so sclk must stay high and low two clocks at least
   always_comb begin
      next_sclk_prev = spi_sclk;
      next_bit_count = bit_count;
      next_rx_shift = rx_shift;
      next_tx_shift = tx_shift;
      next_is_read = is_read;
      next_load_pending = 1'b0;
      next_access = access;
      next_access.write = 1'b0;
      if (spi_ss_n) begin
         next_bit_count = 5'h00;
      end else begin
         if (load_pending) begin
            next_tx_shift = read_data; // read word fetched once the address is known
         end else if (fall && bit_count > 5'h08) begin
            next_tx_shift = {tx_shift[14:0], 1'b0};
         end
         if (rise) begin
            next_rx_shift = {rx_shift[14:0], spi_mosi};
            next_bit_count = bit_count + 5'h01;
            if (bit_count == `CMD_LAST_BIT) begin
               next_is_read = rx_shift[`CMD_READ_BIT];
               next_access.addr = {rx_shift[5:0], spi_mosi};
               next_load_pending = 1'b1;
            end
            if (bit_count == `FRAME_LAST_BIT) begin
               next_bit_count = 5'h00; // another command may follow in the same select
               if (!is_read) begin
                  next_access.write = 1'b1;
                  next_access.wdata = {rx_shift[14:0], spi_mosi};
               end
            end
         end
      end
   end

   // frame state registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sclk_prev <= 1'b0;
         bit_count <= 5'h00;
         rx_shift <= 16'h0000;
         tx_shift <= 16'h0000;
         is_read <= 1'b0;
         load_pending <= 1'b0;
         access <= '0;
      end else begin
         sclk_prev <= next_sclk_prev;
         bit_count <= next_bit_count;
         rx_shift <= next_rx_shift;
         tx_shift <= next_tx_shift;
         is_read <= next_is_read;
         load_pending <= next_load_pending;
         access <= next_access;
      end
   end

   // miso drives only during the data phase of a read
   assign spi_miso = tx_shift[15];
   assign spi_miso_oe = ~spi_ss_n & is_read & (bit_count >= 5'h08);

endmodule

/* File: hdl/radio_control_register_bank.sv */
// control and status register bank of the 2.4 ghz radio section
`timescale 1ns/1ns
`include "radio_regs_cfg.svh"
module radio_control_register_bank import radio_regs_pkg::*; (
   // system
   input wire logic clock,
   input wire logic reset,
   // spi pins
   input wire logic spi_ss_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // analog radio
   input wire analog_status_s analog_status,
   input wire logic id_alt_strap,
   output radio_ctrl_s radio
);

   // ************************************************
   // spi access
   // ************************************************
   reg_access_s access;
   logic [15:0] read_data;

   spi_frame_engine u_spi_frame_engine (
      .clock(clock),
      .reset(reset),
      .spi_ss_n(spi_ss_n),
      .spi_sclk(spi_sclk),
      .spi_mosi(spi_mosi),
      .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe),
      .read_data(read_data),
      .access(access)
   );

   // ************************************************
   // writable registers
   // ************************************************
   logic tx_start, next_tx_start;
   logic rx_start, next_rx_start;
   logic [6:0] channel_number, next_channel_number;
   logic [3:0] amplifier_gain, next_amplifier_gain;
   logic osc_gain_enable, next_osc_gain_enable;
   logic carrier_only, next_carrier_only;
   logic signal_meter_off, next_signal_meter_off;
   logic auto_cal_enable, next_auto_cal_enable;
   logic [4:0] regulator_sleep_current, next_regulator_sleep_current;

   // only documented fields are stored, so reserved bits cannot hold state
   always_comb begin
      next_tx_start = tx_start;
      next_rx_start = rx_start;
      next_channel_number = channel_number;
      next_amplifier_gain = amplifier_gain;
      next_osc_gain_enable = osc_gain_enable;
      next_carrier_only = carrier_only;
      next_signal_meter_off = signal_meter_off;
      next_auto_cal_enable = auto_cal_enable;
      next_regulator_sleep_current = regulator_sleep_current;
      if (access.write) begin
         case (access.addr)
            `ADDR_TXRX: begin
               next_tx_start = access.wdata[`TX_START_BIT];
               next_rx_start = access.wdata[`RX_START_BIT];
               next_channel_number = access.wdata[`CHANNEL_LSB +: 7];
            end
            `ADDR_AMP: begin
               next_amplifier_gain = access.wdata[`GAIN_LSB +: 4];
            end
            `ADDR_OSC: begin
               next_osc_gain_enable = access.wdata[`OSC_BIT];
            end
            `ADDR_CARRIER: begin
               next_carrier_only = access.wdata[`CARRIER_BIT];
               next_signal_meter_off = access.wdata[`METER_OFF_BIT];
            end
            `ADDR_CAL: begin
               next_auto_cal_enable = access.wdata[`AUTO_CAL_BIT];
            end
            `ADDR_SLEEP: begin
               next_regulator_sleep_current = access.wdata[`SLEEP_LSB +: 5];
            end
            default: begin
               // read-only and unknown addresses ignore writes
            end
         endcase
      end
   end

   // writable register flops
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tx_start <= 1'b0;
         rx_start <= 1'b0;
         channel_number <= `CHANNEL_RESET;
         amplifier_gain <= `GAIN_RESET;
         osc_gain_enable <= 1'b1;
         carrier_only <= 1'b0;
         signal_meter_off <= 1'b0;
         auto_cal_enable <= 1'b0;
         regulator_sleep_current <= `SLEEP_RESET;
      end else begin
         tx_start <= next_tx_start;
         rx_start <= next_rx_start;
         channel_number <= next_channel_number;
         amplifier_gain <= next_amplifier_gain;
         osc_gain_enable <= next_osc_gain_enable;
         carrier_only <= next_carrier_only;
         signal_meter_off <= next_signal_meter_off;
         auto_cal_enable <= next_auto_cal_enable;
         regulator_sleep_current <= next_regulator_sleep_current;
      end
   end

   // ************************************************
   // radio control state machine
   // ************************************************
   radio_state_e state, next_state;
   logic [7:0] cal_count, next_cal_count;
   logic cal_for_tx, next_cal_for_tx;
   logic start_tx, start_rx;

   // both bits set is a host error; the radio then stays idle rather than guess
   assign start_tx = tx_start & ~rx_start;
   assign start_rx = rx_start & ~tx_start;

   // calibration runs a fixed time, then the requested direction begins
   always_comb begin
      next_state = state;
      next_cal_count = cal_count;
      next_cal_for_tx = cal_for_tx;
      case (state)
         st_idle: begin
            next_cal_count = 8'(`CAL_CYCLES - 1);
            next_cal_for_tx = start_tx;
            if (start_tx || start_rx) begin
               if (auto_cal_enable) begin
                  next_state = st_cal;
               end else if (start_tx) begin
                  next_state = st_tx;
               end else begin
                  next_state = st_rx;
               end
            end
         end
         st_cal: begin
            next_cal_count = cal_count - 8'h01;
            if (!(start_tx || start_rx)) begin
               next_state = st_idle;
            end else if (cal_count == 8'h00) begin
               next_state = cal_for_tx ? st_tx : st_rx;
            end
         end
         st_tx: begin
            if (!start_tx) begin
               next_state = st_idle;
            end
         end
         st_rx: begin
            if (!start_rx) begin
               next_state = st_idle;
            end
         end
         default: begin
            next_state = st_idle;
         end
      endcase
   end

   // state machine flops
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state <= st_idle;
         cal_count <= 8'h00;
         cal_for_tx <= 1'b0;
      end else begin
         state <= next_state;
         cal_count <= next_cal_count;
         cal_for_tx <= next_cal_for_tx;
      end
   end

   // ************************************************
   // silicon identity strap
   // ************************************************
   logic id_captured, next_id_captured;
   logic id_alt, next_id_alt;

   // strap is caught on the first edge after reset release, then frozen
   always_comb begin
      next_id_captured = 1'b1;
      next_id_alt = id_captured ? id_alt : id_alt_strap;
   end

   // identity flops
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         id_captured <= 1'b0;
         id_alt <= 1'b0;
      end else begin
         id_captured <= next_id_captured;
         id_alt <= next_id_alt;
      end
   end

   // ************************************************
   // read path and radio outputs
   // ************************************************
   // read mux; reserved bits read zero
   always_comb begin
      read_data = 16'h0000;
      case (access.addr)
         `ADDR_SYNTH_LOCK: read_data[`LOCK_BIT] = analog_status.synth_locked;
         `ADDR_SIGNAL: begin
            if (!signal_meter_off) begin
               read_data[`SIGNAL_LSB +: 6] = analog_status.raw_signal_level;
            end
         end
         `ADDR_TXRX: begin
            read_data[`TX_START_BIT] = tx_start;
            read_data[`RX_START_BIT] = rx_start;
            read_data[`CHANNEL_LSB +: 7] = channel_number;
         end
         `ADDR_AMP: read_data[`GAIN_LSB +: 4] = amplifier_gain;
         `ADDR_OSC: read_data[`OSC_BIT] = osc_gain_enable;
         `ADDR_CARRIER: begin
            read_data[`CARRIER_BIT] = carrier_only;
            read_data[`METER_OFF_BIT] = signal_meter_off;
         end
         `ADDR_CAL: read_data[`AUTO_CAL_BIT] = auto_cal_enable;
         `ADDR_SLEEP: read_data[`SLEEP_LSB +: 5] = regulator_sleep_current;
         `ADDR_REVISION: begin
            read_data[`RF_REV_LSB +: 4] = `RADIO_REVISION;
            read_data[`DIG_REV_LSB +: 3] = `DIGITAL_REVISION;
         end
         `ADDR_SIGNATURE: read_data = `SIGNATURE_VALUE;
         `ADDR_SILICON: read_data = id_alt ? `SILICON_ID_B : `SILICON_ID_A;
         default: read_data = 16'h0000;
      endcase
   end

   // every setting to the analog side comes straight from a flop; the cal, tx and rx active bits are decoded from state
   assign radio.channel_number = channel_number;
   assign radio.amplifier_gain = amplifier_gain;
   assign radio.osc_gain_enable = osc_gain_enable;
   assign radio.carrier_only = carrier_only;
   assign radio.signal_meter_off = signal_meter_off;
   assign radio.regulator_sleep_current = regulator_sleep_current;
   assign radio.cal_active = (state == st_cal);
   assign radio.tx_active = (state == st_tx);
   assign radio.rx_active = (state == st_rx);

   // ************************************************
   // assertions
   // ************************************************
   logic [21:0] config_bits;
   assign config_bits = {tx_start, rx_start, channel_number, amplifier_gain, osc_gain_enable,
      carrier_only, signal_meter_off, auto_cal_enable, regulator_sleep_current};

   a_lock_status_bit: assert property (@(posedge clock) disable iff (reset)
      access.addr == `ADDR_SYNTH_LOCK |-> read_data == {3'h0, analog_status.synth_locked, 12'h000})
      else $error("lock status read mismatch");

   a_signal_level_field: assert property (@(posedge clock) disable iff (reset)
      access.addr == `ADDR_SIGNAL && !signal_meter_off |-> read_data == {analog_status.raw_signal_level, 10'h000})
      else $error("signal level read mismatch");

   a_tx_launch_seq: assert property (@(posedge clock) disable iff (reset)
      access.write && access.addr == `ADDR_TXRX && access.wdata[8] && !access.wdata[7]
      && state == st_idle && !auto_cal_enable |-> ##2 state == st_tx)
      else $error("transmit did not start");

   a_rx_launch_seq: assert property (@(posedge clock) disable iff (reset)
      access.write && access.addr == `ADDR_TXRX && access.wdata[7] && !access.wdata[8]
      && state == st_idle && !auto_cal_enable |-> ##2 state == st_rx)
      else $error("receive did not start");

   a_dual_start_idle: assert property (@(posedge clock) disable iff (reset)
      tx_start && rx_start |=> !radio.tx_active && !radio.rx_active)
      else $error("radio active with both start bits set");

   a_channel_write: assert property (@(posedge clock) disable iff (reset)
      access.write && access.addr == `ADDR_TXRX |=> radio.channel_number == $past(access.wdata[6:0]))
      else $error("channel not taken from write");

   a_gain_write: assert property (@(posedge clock) disable iff (reset)
      access.write && access.addr == `ADDR_AMP |=> radio.amplifier_gain == $past(access.wdata[10:7]))
      else $error("gain not taken from write");

   a_osc_write: assert property (@(posedge clock) disable iff (reset)
      access.write && access.addr == `ADDR_OSC |=> radio.osc_gain_enable == $past(access.wdata[0]))
      else $error("oscillator enable not taken from write");

   a_cal_entry: assert property (@(posedge clock) disable iff (reset)
      state == st_idle && (start_tx || start_rx) |=> (state == st_cal) == $past(auto_cal_enable))
      else $error("calibration entry wrong");

   a_idle_rest: assert property (@(posedge clock) disable iff (reset)
      !tx_start && !rx_start |=> state == st_idle)
      else $error("radio not idle with start bits clear");

   a_revision_fixed: assert property (@(posedge clock) disable iff (reset)
      access.addr == `ADDR_REVISION |-> read_data[15:8] == 8'h00 && read_data[3] == 1'b0)
      else $error("revision reserved bits not zero");

   a_ro_write_ignored: assert property (@(posedge clock) disable iff (reset)
      access.write && (access.addr == `ADDR_SYNTH_LOCK || access.addr == `ADDR_SILICON) |=> $stable(config_bits))
      else $error("read-only write changed state");

endmodule

/* File: test/spi_host_model.sv */
// host microcontroller model acting as spi master of the radio register bank
`timescale 1ns/1ns
module spi_host_model (
   // system
   input wire logic clock,
   // spi pins
   input wire logic spi_miso,
   output logic spi_ss_n,
   output logic spi_sclk,
   output logic spi_mosi
);
   initial begin
      spi_ss_n = 1'b1;
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
   end
   // released data line toggles so no stale bit looks valid
   always @(posedge clock) begin
      if (spi_ss_n) begin
         spi_mosi <= ~spi_mosi;
      end
   end
   // one whole 24-bit frame; each sclk phase lasts 3 clocks, above the 2-clock floor
   task automatic xfer(input logic rd, input logic [5:0] addr, input logic [15:0] wdata,
         output logic [15:0] rdata);
      logic [23:0] frame;
      // the first command bit is the read flag, the next seven the address (top bit zero)
      frame = {rd, 1'b0, addr, wdata};
      rdata = 16'h0000;
      @(posedge clock);
      #1 spi_ss_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_mosi = frame[i];
         repeat (3) @(posedge clock);
         #1 if (i < 16) rdata[i] = spi_miso; // read data taken just before the rise
         spi_sclk = 1'b1;
         repeat (3) @(posedge clock);
         #1 spi_sclk = 1'b0;
      end
      repeat (3) @(posedge clock);
      #1 spi_ss_n = 1'b1;
   endtask
endmodule

/* File: test/radio_control_register_bank_test.sv */
// self-checking testbench of the radio register bank
`timescale 1ns/1ns
`include "radio_regs_cfg.svh"
module radio_control_register_bank_test import radio_regs_pkg::*;;
   logic clock, reset, spi_ss_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, id_alt_strap;
   analog_status_s analog_status;
   radio_ctrl_s radio;
   int err_count;
   int samples_checked;
   int oe_count = 0;
   // counts clocks in which the device drives miso, so reads and writes can be told apart
   always @(posedge clock) begin
      if (spi_miso_oe === 1'b1) oe_count <= oe_count + 1;
   end
   // revision word with the reserved bit 3 fixed at zero
   localparam logic [15:0] rev_word = {8'h00, `RADIO_REVISION, 1'b0, `DIGITAL_REVISION};

   radio_control_register_bank u_radio_control_register_bank (.clock(clock), .reset(reset),
      .spi_ss_n(spi_ss_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .analog_status(analog_status), .id_alt_strap(id_alt_strap),
      .radio(radio));
   spi_host_model u_spi_host_model (.clock(clock), .spi_miso(spi_miso), .spi_ss_n(spi_ss_n),
      .spi_sclk(spi_sclk), .spi_mosi(spi_mosi));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // ****************
   // helpers
   // ****************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask
   task automatic rd(input logic [5:0] addr, input logic [15:0] exp, input string name);
      logic [15:0] d;
      int oe_before;
      oe_before = oe_count;
      u_spi_host_model.xfer(1'b1, addr, 16'h0000, d);
      chk(name, exp, d);
      chk("miso enable on read", 16'h0001, 16'(oe_count != oe_before));
   endtask
   // write then let the register output settle
   task automatic wr(input logic [5:0] addr, input logic [15:0] data);
      logic [15:0] d;
      int oe_before;
      oe_before = oe_count;
      u_spi_host_model.xfer(1'b0, addr, data, d);
      chk("miso enable on write", 16'h0000, 16'(oe_count != oe_before));
      tick(3);
   endtask
   task automatic do_reset(input logic strap);
      id_alt_strap = strap;
      reset = 1'b1;
      tick(4);
      reset = 1'b0;
      tick(2);
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic test_reset_values();
      rd(6'h07, 16'h0000, "txrx reset");
      rd(6'h0a, 16'h0001, "osc reset");
      rd(6'h1d, rev_word, "revision");
      rd(6'h1e, `SIGNATURE_VALUE, "signature");
      rd(6'h1f, `SILICON_ID_A, "silicon id");
      rd(6'h05, 16'h0000, "unmapped");
      chk("idle", 16'h0000, 16'(radio[2:0]));
      $display("test_reset_values done");
   endtask
   task automatic test_fields();
      wr(6'h07, 16'h004e);
      wr(6'h09, 16'hffff);
      wr(6'h0a, 16'h0000);
      wr(6'h1b, 16'hffff);
      chk("channel", 16'h004e, 16'(radio.channel_number));
      chk("gain", 16'h000f, 16'(radio.amplifier_gain));
      chk("osc", 16'h0000, 16'(radio.osc_gain_enable));
      chk("sleep", 16'h001f, 16'(radio.regulator_sleep_current));
      rd(6'h09, 16'h0780, "amp reg");
      rd(6'h1b, 16'hf800, "sleep reg");
      rd(6'h07, 16'h004e, "txrx reg");
      $display("test_fields done");
   endtask
   task automatic test_status();
      analog_status = '{synth_locked: 1'b1, raw_signal_level: 6'h2a};
      rd(6'h03, 16'h1000, "lock set");
      rd(6'h06, 16'ha800, "signal");
      wr(6'h0b, 16'h8200);
      chk("carrier", 16'h0001, 16'(radio.carrier_only));
      chk("meter off", 16'h0001, 16'(radio.signal_meter_off));
      rd(6'h06, 16'h0000, "signal off");
      wr(6'h0b, 16'h0000);
      chk("carrier clr", 16'h0000, 16'(radio.carrier_only));
      analog_status = '{synth_locked: 1'b0, raw_signal_level: 6'h15};
      rd(6'h03, 16'h0000, "lock clr");
      rd(6'h06, 16'h5400, "signal 2");
      $display("test_status done");
   endtask
   task automatic test_radio();
      logic seen_cal;
      int n;
      seen_cal = 1'b0;
      n = 0;
      wr(6'h17, 16'h0004);
      rd(6'h17, 16'h0004, "cal reg");
      wr(6'h07, 16'h0100);
      // bounded wait across the calibration period
      while (radio.tx_active !== 1'b1 && n < 60) begin
         if (radio.cal_active === 1'b1) seen_cal = 1'b1;
         tick(1);
         n++;
      end
      if (radio.tx_active !== 1'b1) begin
         $display("[FAIL] tx start wait expected 1 seen %b", radio.tx_active);
         err_count++;
         report_and_stop();
      end
      chk("cal before tx", 16'h0001, 16'(seen_cal));
      wr(6'h07, 16'h0000);
      chk("idle after tx", 16'h0000, 16'(radio[2:0]));
      wr(6'h17, 16'h0000);
      wr(6'h07, 16'h0080);
      chk("rx no cal", 16'h0001, 16'(radio[2:0]));
      wr(6'h07, 16'h0000);
      wr(6'h07, 16'h0100);
      chk("tx no cal", 16'h0002, 16'(radio[2:0]));
      wr(6'h07, 16'h0000);
      wr(6'h07, 16'h0180); // deliberate clash, radio must stay idle
      chk("both set", 16'h0000, 16'(radio[2:0]));
      $display("test_radio done");
   endtask
   task automatic test_read_only();
      wr(6'h1d, 16'hffff);
      wr(6'h1f, 16'h0000);
      wr(6'h03, 16'hffff);
      rd(6'h1d, rev_word, "revision ro");
      rd(6'h1f, `SILICON_ID_A, "id ro");
      rd(6'h03, 16'h0000, "lock ro");
      do_reset(1'b1);
      rd(6'h1f, `SILICON_ID_B, "alt id");
      $display("test_read_only done");
   endtask

   initial begin
      err_count = 0;
      samples_checked = 0;
      analog_status = '{synth_locked: 1'b0, raw_signal_level: 6'h00};
      do_reset(1'b0);
      test_reset_values();
      test_fields();
      test_status();
      test_radio();
      test_read_only();
      report_and_stop();
   end
endmodule
